// ==== shared/lrd_pkg.sv ====
// package for the differential receive lane: offsets, fields, resets, types
package lrd_pkg;

  // register byte offsets
  localparam logic [3:0] LRD_OFS_CFG  = 4'h0;
  localparam logic [3:0] LRD_OFS_STAT = 4'h4;
  localparam logic [3:0] LRD_OFS_WORD = 4'h8;
  localparam logic [3:0] LRD_OFS_CNT  = 4'hc;

  // config field positions
  localparam int LRD_CFG_DES_BIT = 0;
  localparam int LRD_CFG_WID_LSB = 1;
  localparam int LRD_CFG_ALT_BIT = 5;
  localparam int LRD_CFG_ODT_BIT = 6;
  localparam int LRD_CFG_DLY_LSB = 7;

  // status field positions
  localparam int LRD_ST_OVR_BIT  = 0;
  localparam int LRD_ST_SLIP_BIT = 1;
  localparam int LRD_ST_LVL_LSB  = 2;
  localparam int LRD_ST_BYP_BIT  = 4;
  localparam int LRD_ST_ALT_BIT  = 5;

  // widths and ranges
  localparam int         LRD_WORD_W     = 8;
  localparam int         LRD_DLY_W      = 6;
  localparam logic [3:0] LRD_WID_BYPASS = 4'h1;
  localparam logic [3:0] LRD_WID_MIN    = 4'h2;
  localparam logic [3:0] LRD_WID_MAX    = 4'h8;
  localparam logic [3:0] LRD_CNT_SAT    = 4'hf;
  localparam logic [5:0] LRD_DLY_MAX    = 6'h3f;

  // analog figures, informative only
  localparam int LRD_DLY_STEP_PS = 25;
  localparam int LRD_ODT_OHM     = 100;
  localparam int LRD_MAX_MBPS    = 800;

  // values after reset, and the word buffer depth
  localparam logic       LRD_RST_DES = 1'h1;
  localparam logic [3:0] LRD_RST_WID = 4'h8;
  localparam logic       LRD_RST_ALT = 1'h0;
  localparam logic       LRD_RST_ODT = 1'h0;
  localparam logic [5:0] LRD_RST_DLY = 6'h00;
  localparam logic [1:0] LRD_BUF_DEPTH = 2'h2;

  typedef enum logic [1:0] {LRD_M_DESER, LRD_M_BYPASS, LRD_M_ALT} lrd_mode_t;

  // legal widths are 1 (bypass) and 2 to 8
  function automatic logic lrd_width_legal(input logic [3:0] w);
    return (w >= LRD_WID_BYPASS) && (w <= LRD_WID_MAX);
  endfunction

  // low bits kept for a word of width w
  function automatic logic [7:0] lrd_word_mask(input logic [3:0] w);
    return 8'hff >> (LRD_WID_MAX - w);
  endfunction

endpackage

// ==== rtl/lrd_pair_buf.sv ====
// two-entry word buffer with valid and ready on both sides
`timescale 1ns/100ps
module lrd_pair_buf (
  input  wire logic        clk_sys_in,
  input  wire logic        rst_in,
  input  wire logic        in_valid_in,
  output logic             in_ready_out,
  input  wire logic [7:0]  in_data_in,
  output logic             out_valid_out,
  input  wire logic        out_ready_in,
  output logic [7:0]       out_data_out,
  output logic [1:0]       level_out
);
  import lrd_pkg::*;

  typedef struct packed {
    logic [7:0] d0;
    logic [7:0] d1;
    logic [1:0] cnt;
  } lrd_buf_st_t;

  lrd_buf_st_t st_reg;
  lrd_buf_st_t st_next;
  logic        push;
  logic        pop;

  // handshakes
  assign in_ready_out  = (st_reg.cnt != LRD_BUF_DEPTH);
  assign out_valid_out = (st_reg.cnt != 2'h0);
  assign out_data_out  = st_reg.d0;
  assign level_out     = st_reg.cnt;
  assign push          = in_valid_in && in_ready_out;
  assign pop           = out_valid_out && out_ready_in;

  // head holds the oldest word
  always_comb begin
    st_next = st_reg;
    if (push && pop) begin
      if (st_reg.cnt == 2'h1) begin
        st_next.d0 = in_data_in;
      end else begin
        st_next.d0 = st_reg.d1;
        st_next.d1 = in_data_in;
      end
    end else if (pop) begin
      st_next.d0  = st_reg.d1;
      st_next.cnt = st_reg.cnt - 2'h1;
    end else if (push) begin
      if (st_reg.cnt == 2'h0) begin
        st_next.d0 = in_data_in;
      end else begin
        st_next.d1 = in_data_in;
      end
      st_next.cnt = st_reg.cnt + 2'h1;
    end
  end

  // state register
  always_ff @(posedge clk_sys_in) begin
    if (rst_in) begin
      st_reg <= '0;
    end else begin
      st_reg <= st_next;
    end
  end

  chk_buf_no_overfill: assert property (@(posedge clk_sys_in) disable iff (rst_in)
    st_reg.cnt <= LRD_BUF_DEPTH)
    else $error("word buffer holds more than two entries");

endmodule

// ==== rtl/lrd_rx_lane.sv ====
// differential serial receive lane with deserializer, bypass and side output
// Summary of operation
// R1 - word width equals configured factor; width one bypasses deserializer
// R2 - factor selectable as 2 to 8 bits per word only
// R3 - bits shift in on serial clock; word latched on parallel clock
// R4 - words leave aligned, updated on rising edge of parallel clock
// R5 - with deserializer off, pad level passes through as single bit
// R6 - connection setting routes pad to PLL clock input instead
// R7 - side output live only in bypass (deserializer off or width one) with alternate connection
// R8 - static input delay settable 0 to 63, about 25 ps per step
// R9 - termination enable connects internal 100 ohm across pad pair
// R10 - transmitter never drives faster than 800 Mbps per lane
`timescale 1ns/100ps
module lrd_rx_lane (
  input  wire logic        clk_sys_in,
  input  wire logic        rst_in,
  input  wire logic        diff_positive_pad_in,
  input  wire logic        diff_negative_pad_in,
  input  wire logic        serial_bit_clock_in,
  input  wire logic        parallel_word_clock_in,
  input  wire logic [3:0]  reg_addr_in,
  input  wire logic [31:0] reg_wdata_in,
  input  wire logic        reg_wr_in,
  input  wire logic        reg_rd_in,
  output logic [31:0]      reg_rdata_out,
  output logic [7:0]       word_data_out,
  output logic             word_valid_out,
  input  wire logic        word_ready_in,
  output logic             bypass_side_output_out,
  output logic             odt_enable_out,
  output logic [5:0]       delay_code_out
);
  import lrd_pkg::*;

  typedef struct packed {
    logic        p_s1;
    logic        p_s2;
    logic        n_s1;
    logic        n_s2;
    logic        fc_s1;
    logic        fc_s2;
    logic        fc_d;
    logic        sc_s1;
    logic        sc_s2;
    logic        sc_d;
    logic        bit_q;
    logic [7:0]  shreg;
    logic [3:0]  bit_cnt;
    logic [7:0]  last_word;
    logic        des_en;
    logic [3:0]  wid;
    logic        alt_sel;
    logic        odt;
    logic [5:0]  dly;
    logic        ovr;
    logic        slip;
    logic        alt_q;
    logic [15:0] word_cnt;
    logic [31:0] rdata;
  } lrd_lane_st_t;

  lrd_lane_st_t st_reg;
  lrd_lane_st_t st_next;
  lrd_mode_t    mode;
  logic         bypass;
  logic         fc_rise;
  logic         sc_rise;
  logic         push_valid;
  logic         push_ready;
  logic [7:0]   push_data;
  logic [1:0]   buf_level;
  logic [3:0]   wr_wid;
  logic         wr_cfg;
  logic         wr_stat;
  logic         wr_cnt;

  // edges of the two pad-side clocks after their synchronisers
  assign fc_rise = st_reg.fc_s2 && !st_reg.fc_d;
  assign sc_rise = st_reg.sc_s2 && !st_reg.sc_d;

  // register strobes
  assign wr_cfg  = reg_wr_in && (reg_addr_in == LRD_OFS_CFG);
  assign wr_stat = reg_wr_in && (reg_addr_in == LRD_OFS_STAT);
  assign wr_cnt  = reg_wr_in && (reg_addr_in == LRD_OFS_CNT);
  assign wr_wid  = reg_wdata_in[LRD_CFG_WID_LSB +: 4];

  // mode from configuration
  assign bypass = !st_reg.des_en || (st_reg.wid == LRD_WID_BYPASS); // R1 R5
  always_comb begin
    mode = LRD_M_DESER;
    if (bypass) begin
      mode = st_reg.alt_sel ? LRD_M_ALT : LRD_M_BYPASS; // R6 R7
    end
  end

  // word offered to the buffer on each parallel clock edge outside alternate mode
  always_comb begin
    push_data = 8'h00;
    unique case (mode)
      LRD_M_DESER: begin
        push_data = st_reg.shreg & lrd_word_mask(st_reg.wid); // R1 R4
      end
      LRD_M_BYPASS: begin
        push_data = {7'h00, st_reg.bit_q}; // R5
      end
      LRD_M_ALT: begin
        push_data = 8'h00;
      end
    endcase
  end
  assign push_valid = sc_rise && (mode != LRD_M_ALT); // R3 R4

  // lane state
  always_comb begin
    st_next = st_reg;
    // two-stage synchronisers for pads and clocks
    st_next.p_s1  = diff_positive_pad_in;
    st_next.p_s2  = st_reg.p_s1;
    st_next.n_s1  = diff_negative_pad_in;
    st_next.n_s2  = st_reg.n_s1;
    st_next.fc_s1 = serial_bit_clock_in;
    st_next.fc_s2 = st_reg.fc_s1;
    st_next.fc_d  = st_reg.fc_s2;
    st_next.sc_s1 = parallel_word_clock_in;
    st_next.sc_s2 = st_reg.sc_s1;
    st_next.sc_d  = st_reg.sc_s2;
    // differential level; equal pads hold last level
    if (st_reg.p_s2 != st_reg.n_s2) begin
      st_next.bit_q = st_reg.p_s2; // R5
    end
    // serial shift, newest bit in the low end
    if (fc_rise) begin
      st_next.shreg = {st_reg.shreg[6:0], st_reg.bit_q}; // R3
    end
    // bits seen since the last word, saturating
    if (sc_rise) begin
      st_next.bit_cnt = fc_rise ? 4'h1 : 4'h0;
    end else if (fc_rise && (st_reg.bit_cnt != LRD_CNT_SAT)) begin
      st_next.bit_cnt = st_reg.bit_cnt + 4'h1;
    end
    // word taken on the parallel edge
    if (push_valid) begin
      st_next.last_word = push_data; // R4
    end
    if (push_valid && push_ready) begin
      st_next.word_cnt = st_reg.word_cnt + 16'h0001;
    end else if (wr_cnt) begin
      st_next.word_cnt = 16'h0000;
    end
    // side output toward the clock input of the PLL
    st_next.alt_q = (mode == LRD_M_ALT) && st_reg.bit_q; // R6 R7
    // configuration writes
    if (wr_cfg) begin
      st_next.des_en  = reg_wdata_in[LRD_CFG_DES_BIT];
      st_next.alt_sel = reg_wdata_in[LRD_CFG_ALT_BIT];
      st_next.odt     = reg_wdata_in[LRD_CFG_ODT_BIT]; // R9
      st_next.dly     = reg_wdata_in[LRD_CFG_DLY_LSB +: LRD_DLY_W]; // R8
      if (lrd_width_legal(wr_wid)) begin
        st_next.wid = wr_wid; // R2
      end
    end
    // sticky flags: write one clears, a new event wins
    if (wr_stat && reg_wdata_in[LRD_ST_OVR_BIT]) begin
      st_next.ovr = 1'b0;
    end
    if (wr_stat && reg_wdata_in[LRD_ST_SLIP_BIT]) begin
      st_next.slip = 1'b0;
    end
    if (push_valid && !push_ready) begin
      st_next.ovr = 1'b1;
    end
    // judge the bits counted before this edge, not the restarted count
    if (sc_rise && (mode == LRD_M_DESER) && (st_reg.bit_cnt != st_reg.wid)) begin
      st_next.slip = 1'b1; // R4
    end
    // read data valid only in the cycle after the strobe
    st_next.rdata = 32'h0000_0000;
    if (reg_rd_in) begin
      case (reg_addr_in)
        LRD_OFS_CFG: begin
          st_next.rdata[LRD_CFG_DES_BIT]             = st_reg.des_en;
          st_next.rdata[LRD_CFG_WID_LSB +: 4]        = st_reg.wid;
          st_next.rdata[LRD_CFG_ALT_BIT]             = st_reg.alt_sel;
          st_next.rdata[LRD_CFG_ODT_BIT]             = st_reg.odt;
          st_next.rdata[LRD_CFG_DLY_LSB +: LRD_DLY_W] = st_reg.dly;
        end
        LRD_OFS_STAT: begin
          st_next.rdata[LRD_ST_OVR_BIT]      = st_reg.ovr;
          st_next.rdata[LRD_ST_SLIP_BIT]     = st_reg.slip;
          st_next.rdata[LRD_ST_LVL_LSB +: 2] = buf_level;
          st_next.rdata[LRD_ST_BYP_BIT]      = bypass;
          st_next.rdata[LRD_ST_ALT_BIT]      = (mode == LRD_M_ALT);
        end
        LRD_OFS_WORD: begin
          st_next.rdata[7:0] = st_reg.last_word;
        end
        LRD_OFS_CNT: begin
          st_next.rdata[15:0] = st_reg.word_cnt;
        end
        default: begin
          st_next.rdata = 32'h0000_0000;
        end
      endcase
    end
  end

  // state register with synchronous reset
  always_ff @(posedge clk_sys_in) begin
    if (rst_in) begin
      st_reg         <= '0;
      st_reg.des_en  <= LRD_RST_DES;
      st_reg.wid     <= LRD_RST_WID;
      st_reg.alt_sel <= LRD_RST_ALT;
      st_reg.odt     <= LRD_RST_ODT;
      st_reg.dly     <= LRD_RST_DLY;
    end else begin
      st_reg <= st_next;
    end
  end

  // outputs from flops
  assign reg_rdata_out          = st_reg.rdata;
  assign bypass_side_output_out = st_reg.alt_q; // R7
  assign odt_enable_out         = st_reg.odt; // R9
  assign delay_code_out         = st_reg.dly; // R8

  // buffer between lane and core; a stall by the core fills it
  lrd_pair_buf u_buf (
    .clk_sys_in    (clk_sys_in),
    .rst_in        (rst_in),
    .in_valid_in   (push_valid),
    .in_ready_out  (push_ready),
    .in_data_in    (push_data),
    .out_valid_out (word_valid_out),
    .out_ready_in  (word_ready_in),
    .out_data_out  (word_data_out),
    .level_out     (buf_level)
  );

  // checks
  chk_word_mask_width: assert property ( // R1
    @(posedge clk_sys_in) disable iff (rst_in)
    push_valid && (mode == LRD_M_DESER) |-> (push_data & ~lrd_word_mask(st_reg.wid)) == 8'h00)
    else $error("word carries bits above the configured width");

  chk_width_stays_legal: assert property ( // R2
    @(posedge clk_sys_in) disable iff (rst_in)
    wr_cfg && !lrd_width_legal(wr_wid) |=> st_reg.wid == $past(st_reg.wid))
    else $error("illegal width was accepted");

  chk_shift_only_edge: assert property ( // R3
    @(posedge clk_sys_in) disable iff (rst_in)
    !fc_rise |=> $stable(st_reg.shreg))
    else $error("shift register moved without a serial clock edge");

  chk_word_on_slow: assert property ( // R4
    @(posedge clk_sys_in) disable iff (rst_in)
    $rose(st_reg.sc_s2) && (mode != LRD_M_ALT) |-> push_valid ##1 st_reg.last_word == $past(push_data))
    else $error("parallel clock edge did not latch a word");

  // pad level one cycle back, taken straight from the synchroniser
  chk_bypass_single_bit: assert property ( // R5
    @(posedge clk_sys_in) disable iff (rst_in)
    push_valid && (mode == LRD_M_BYPASS) && ($past(st_reg.p_s2) != $past(st_reg.n_s2))
      |-> push_data == {7'h00, $past(st_reg.p_s2)})
    else $error("bypass word is not the pad level");

  chk_alt_follows_pad: assert property ( // R6
    @(posedge clk_sys_in) disable iff (rst_in)
    mode == LRD_M_ALT |=> bypass_side_output_out == $past(st_reg.bit_q))
    else $error("side output does not follow the pad");

  chk_alt_gated_off: assert property ( // R7
    @(posedge clk_sys_in) disable iff (rst_in)
    mode != LRD_M_ALT |=> !bypass_side_output_out)
    else $error("side output live outside alternate bypass");

  chk_delay_code_load: assert property ( // R8
    @(posedge clk_sys_in) disable iff (rst_in)
    wr_cfg |=> delay_code_out == $past(reg_wdata_in[LRD_CFG_DLY_LSB +: LRD_DLY_W]) ##1 $stable(delay_code_out) || $past(wr_cfg))
    else $error("delay code not loaded from write");

  chk_odt_enable_load: assert property ( // R9
    @(posedge clk_sys_in) disable iff (rst_in)
    wr_cfg |=> odt_enable_out == $past(reg_wdata_in[LRD_CFG_ODT_BIT]))
    else $error("termination enable not loaded from write");

endmodule

// ==== tb/lrd_tx_model.sv ====
// behavioural serial transmitter facing the receive lane
`timescale 1ns/100ps
module lrd_tx_model (
  input  wire logic clk_sys_in,
  output logic      pad_p_out,
  output logic      pad_n_out,
  output logic      ser_clk_out,
  output logic      par_clk_out
);
  // half period of both clocks in system cycles, 3 or more
  int half_cyc = 3;

  // pads idle at the weak pull-up level, clocks stand still
  initial begin
    pad_p_out = 1'h1;
    pad_n_out = 1'h1;
    ser_clk_out = 1'h0;
    par_clk_out = 1'h0;
  end

  // one clock half period, keeps the bit rate low
  task automatic hold();
    repeat (half_cyc) @(posedge clk_sys_in);
  endtask

  // oldest bit first, then one parallel clock rise
  task automatic send_word(input int w, input logic [7:0] d);
    for (int i = w - 1; i >= 0; i--) begin
      pad_p_out <= d[i];
      pad_n_out <= ~d[i];
      hold();
      ser_clk_out <= 1'h1;
      hold();
      ser_clk_out <= 1'h0;
    end
    hold();
    par_clk_out <= 1'h1;
    hold();
    par_clk_out <= 1'h0;
    pad_p_out <= 1'h1;
    pad_n_out <= 1'h1;
    hold();
  endtask
endmodule

// ==== tb/lrd_rx_lane_tb_top.sv ====
// self-checking bench for the differential receive lane
`timescale 1ns/100ps
module lrd_rx_lane_tb_top;
  import lrd_pkg::*;
  logic        clk_sys_in = 1'h0;
  logic        rst_in = 1'h1;
  logic [3:0]  reg_addr_in = 4'h0;
  logic [31:0] reg_wdata_in = 32'h0;
  logic        reg_wr_in = 1'h0;
  logic        reg_rd_in = 1'h0;
  logic        word_ready_in = 1'h0;
  logic        pad_p;
  logic        pad_n;
  logic        ser_clk;
  logic        par_clk;
  logic [31:0] reg_rdata_out;
  logic [7:0]  word_data_out;
  logic        word_valid_out;
  logic        side_out;
  logic        odt_enable_out;
  logic [5:0]  delay_code_out;
  logic [31:0] rd;
  int          err_count = 0;
  int          cmp_count = 0;

  // 125 MHz system clock
  always #4 clk_sys_in = ~clk_sys_in;

  lrd_tx_model partner_u (.clk_sys_in(clk_sys_in), .pad_p_out(pad_p), .pad_n_out(pad_n),
    .ser_clk_out(ser_clk), .par_clk_out(par_clk));

  lrd_rx_lane dut_u (.clk_sys_in(clk_sys_in), .rst_in(rst_in), .diff_positive_pad_in(pad_p),
    .diff_negative_pad_in(pad_n), .serial_bit_clock_in(ser_clk), .parallel_word_clock_in(par_clk),
    .reg_addr_in(reg_addr_in), .reg_wdata_in(reg_wdata_in), .reg_wr_in(reg_wr_in), .reg_rd_in(reg_rd_in),
    .reg_rdata_out(reg_rdata_out), .word_data_out(word_data_out), .word_valid_out(word_valid_out),
    .word_ready_in(word_ready_in), .bypass_side_output_out(side_out), .odt_enable_out(odt_enable_out),
    .delay_code_out(delay_code_out));

  // config word: enable, width, alternate, termination, delay
  function automatic logic [31:0] cfg(input logic d, input logic [3:0] w, input logic a, input logic o,
                                      input logic [5:0] y);
    return {19'h0, y, o, a, w, d};
  endfunction

  task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
    cmp_count++;
    if (got !== exp) begin
      err_count++;
      $display("mismatch %s expected %h seen %h", name, exp, got);
    end
  endtask

  task automatic reg_wr(input logic [3:0] a, input logic [31:0] d);
    @(posedge clk_sys_in);
    reg_addr_in <= a;
    reg_wdata_in <= d;
    reg_wr_in <= 1'h1;
    @(posedge clk_sys_in);
    reg_wr_in <= 1'h0;
  endtask

  // read data stand only in the cycle after the strobe
  task automatic reg_rd(input logic [3:0] a, output logic [31:0] d);
    @(posedge clk_sys_in);
    reg_addr_in <= a;
    reg_rd_in <= 1'h1;
    @(posedge clk_sys_in);
    reg_rd_in <= 1'h0;
    #1 d = reg_rdata_out;
  endtask

  // wait for a word, compare it, accept it
  task automatic take_word(input logic [7:0] exp);
    int n;
    n = 0;
    // let a pop launched at this edge settle before looking
    #1;
    while (word_valid_out !== 1'h1 && n < 200) begin
      @(posedge clk_sys_in);
      #1 n++;
    end
    chk("word_valid", 32'h1, {31'h0, word_valid_out});
    chk("word_data", {24'h0, exp}, {24'h0, word_data_out});
    @(posedge clk_sys_in);
    word_ready_in <= 1'h1;
    @(posedge clk_sys_in);
    word_ready_in <= 1'h0;
  endtask

  task automatic t_reset();
    reg_rd(LRD_OFS_CFG, rd);
    chk("cfg_reset", cfg(1'h1, 4'h8, 1'h0, 1'h0, 6'h00), rd);
    chk("odt_reset", 32'h0, {31'h0, odt_enable_out});
    chk("delay_reset", 32'h0, {26'h0, delay_code_out});
    reg_rd(4'h2, rd);
    chk("unmapped", 32'h0, rd);
  endtask

  // every factor, widest first, then an illegal width
  task automatic t_widths();
    logic [7:0] d;
    for (int w = 8; w >= 2; w--) begin
      d = 8'h5a ^ 8'(w);
      reg_wr(LRD_OFS_CFG, cfg(1'h1, 4'(w), 1'h0, 1'h0, 6'h00));
      partner_u.send_word(w, d);
      take_word(d & (8'hff >> (8 - w)));
    end
    reg_wr(LRD_OFS_CFG, cfg(1'h1, 4'h9, 1'h0, 1'h1, 6'h00));
    reg_rd(LRD_OFS_CFG, rd);
    chk("cfg_bad_width", cfg(1'h1, 4'h2, 1'h0, 1'h1, 6'h00), rd);
  endtask

  // deserializer off, then width one
  task automatic t_bypass();
    for (int i = 0; i < 4; i++) begin
      reg_wr(LRD_OFS_CFG, (i < 2) ? cfg(1'h0, 4'h8, 1'h0, 1'h0, 6'h00) : cfg(1'h1, 4'h1, 1'h0, 1'h0, 6'h00));
      partner_u.send_word(1, {7'h0, ~i[0]});
      take_word({7'h0, ~i[0]});
    end
  endtask

  task automatic t_alt();
    reg_wr(LRD_OFS_CFG, cfg(1'h0, 4'h1, 1'h1, 1'h0, 6'h00));
    for (int b = 0; b < 2; b++) begin
      // idle pads are equal, so the lane keeps the last sent level
      partner_u.send_word(1, {7'h0, 1'(b)});
      repeat (6) @(posedge clk_sys_in);
      #1 chk("side_level", 32'(b), {31'h0, side_out});
      chk("alt_no_word", 32'h0, {31'h0, word_valid_out});
    end
    reg_rd(LRD_OFS_STAT, rd);
    chk("stat_alt", 32'h30, rd);
    reg_wr(LRD_OFS_CFG, cfg(1'h1, 4'h8, 1'h1, 1'h0, 6'h00));
    partner_u.send_word(8, 8'h81);
    take_word(8'h81);
    chk("side_deser", 32'h0, {31'h0, side_out});
  endtask

  task automatic t_odt_dly();
    reg_wr(LRD_OFS_CFG, cfg(1'h1, 4'h8, 1'h0, 1'h1, 6'h3f));
    repeat (2) @(posedge clk_sys_in);
    #1 chk("odt_on", 32'h1, {31'h0, odt_enable_out});
    chk("delay_max", 32'h3f, {26'h0, delay_code_out});
    reg_wr(LRD_OFS_CFG, cfg(1'h1, 4'h8, 1'h0, 1'h0, 6'h00));
    repeat (2) @(posedge clk_sys_in);
    #1 chk("odt_off", 32'h0, {31'h0, odt_enable_out});
    chk("delay_min", 32'h0, {26'h0, delay_code_out});
  endtask

  // core stalls for three words: two kept in order, third dropped
  task automatic t_stall();
    partner_u.send_word(8, 8'h11);
    partner_u.send_word(8, 8'h22);
    partner_u.send_word(8, 8'h33);
    reg_rd(LRD_OFS_STAT, rd);
    chk("stat_full", 32'h9, rd);
    take_word(8'h11);
    take_word(8'h22);
    reg_wr(LRD_OFS_STAT, 32'h1);
    reg_rd(LRD_OFS_STAT, rd);
    chk("stat_clear", 32'h0, rd);
    // fourteen words were accepted so far; the dropped one was still offered
    reg_rd(LRD_OFS_CNT, rd);
    chk("word_count", 32'he, rd);
    reg_rd(LRD_OFS_WORD, rd);
    chk("last_word", 32'h33, rd);
    reg_wr(LRD_OFS_CNT, 32'h0);
    reg_rd(LRD_OFS_CNT, rd);
    chk("count_clear", 32'h0, rd);
    // seven bits against width eight: the word leaves, slip is flagged
    partner_u.send_word(7, 8'h05);
    take_word(8'h85);
    reg_rd(LRD_OFS_STAT, rd);
    chk("stat_slip", 32'h2, rd);
    reg_rd(LRD_OFS_CNT, rd);
    chk("count_one", 32'h1, rd);
  endtask

  task automatic end_sim();
    $display("errors %0d checks %0d", err_count, cmp_count);
    if (err_count == 0 && cmp_count > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask

  // watchdog well beyond the expected run
  initial begin
    #600000;
    err_count++;
    end_sim();
  end

  initial begin
    repeat (10) @(posedge clk_sys_in);
    rst_in <= 1'h0;
    repeat (4) @(posedge clk_sys_in);
    t_reset();
    t_widths();
    t_bypass();
    t_alt();
    t_odt_dly();
    t_stall();
    end_sim();
  end
endmodule
